// ===== ump_top.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - Eight data lines driven only during reads
// - Driver disable high unless CPU reads
// - Carrier detect level reads as bit 7
// - Data set ready level reads as bit 5
// - Bits 3 and 1 flag changes since read
// - Carrier or ready change interrupts when enabled
// - Terminal ready low when its bit set
// - Terminal ready inactive on reset, loop, clear
// - Interrupt high for any enabled source
// - Interrupt drops when serviced or reset
// - Master reset clears registers, idles outputs
// - User outputs low when their bit set
// - User outputs high on reset, loop, clear
// - Receiver timed by external 16x clock
// - Clear to send bit 4, change bit 0
// - Ring level bit 6, trailing edge bit 2
// - Request to send follows bit 1, auto mode
module ump_top (
    input wire logic sys_clk, // 10 MHz system clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [7:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready, always high
    output logic pslverr, // APB error on unmapped address
    output logic [7:0] cpuDataOut, // Data lines, driven value
    output logic cpuDataOe_n, // Data lines enable, low drives
    output logic busDriverDisable, // High when CPU is not reading
    input wire logic dcd_n, // Carrier detect pin, active low
    input wire logic dsr_n, // Data set ready pin, active low
    input wire logic cts_n, // Clear to send pin, active low
    input wire logic ri_n, // Ring indicator pin, active low
    output logic dtr_n, // Terminal ready pin, active low
    output logic rts_n, // Request to send pin, active low
    output logic userPinA_n, // User output A, active low
    output logic userPinB_n, // User output B, active low
    input wire logic masterClear, // Master reset pin, active high
    input wire logic rclk16x, // Receiver 16x baud clock pin
    output logic rxSampleTick, // One pulse per receiver clock rise
    input wire logic rxErrEvt, // Receiver error event pulse
    input wire logic rxDataEvt, // Received data or timeout pulse
    input wire logic thrEmptyEvt, // Transmit holding empty pulse
    input wire logic rxAboveThresh, // Receiver level over threshold
    output logic txCtsHold, // Transmitter held by auto clear to send
    output logic irqOut // Interrupt, active high level
);
    typedef struct packed {
        logic [6:0] modem_control_reg;
        logic [3:0] lvlPrev;
        logic [3:0] delta;
        logic dtrN;
        logic rtsN;
        logic userAN;
        logic userBN;
        logic rclkPrev;
        logic rxTick;
    } ump_state_t;

    localparam ump_state_t STATE_RST = '{
        modem_control_reg: ump_pkg::MCR_RST, lvlPrev: 4'h0, delta: 4'h0, dtrN: 1'b1, rtsN: 1'b1,
        userAN: 1'b1, userBN: 1'b1, rclkPrev: 1'b0, rxTick: 1'b0};

    ump_state_t st_r;
    ump_state_t st_nxt;
    logic [5:0] pinSync;
    logic rst;
    logic loopOn;
    logic [3:0] lvl;
    logic [3:0] chg;
    logic [7:0] msrVal;
    logic rdAcc;
    logic wrAcc;
    logic msrRead;
    logic mapped;
    logic modemEvt;
    logic [3:0] intSet;
    logic [3:0] intClr;
    logic [3:0] intStat;
    logic [3:0] intMask;

    // Every modem pin, master clear and the receiver clock pass two flops before any logic sees them
    ump_sync #(.W(ump_pkg::PIN_W), .RST_VAL(ump_pkg::PIN_SYNC_RST)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .din({rclk16x, masterClear, ri_n, cts_n, dsr_n, dcd_n}),
        .dout(pinSync)
    );

    // Master clear acts like the system reset once synchronised
    assign rst = sys_rst | pinSync[ump_pkg::PIN_MCLR];
    assign loopOn = st_r.modem_control_reg[ump_pkg::MCR_LOOP];

    // APB decode; zero wait states, so every access ends in its first access cycle
    assign rdAcc = psel & penable & ~pwrite;
    assign wrAcc = psel & penable & pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == ump_pkg::ADDR_INT_STAT) | (paddr == ump_pkg::ADDR_INT_MASK)
        | (paddr == ump_pkg::ADDR_MODEM_CTRL) | (paddr == ump_pkg::ADDR_MODEM_STAT);
    assign pslverr = psel & penable & ~mapped;
    assign msrRead = rdAcc & (paddr == ump_pkg::ADDR_MODEM_STAT);

    // Asserted levels; in loop mode the control bits stand in for the pins
    always_comb begin
        lvl = ~pinSync[3:0];
        if (loopOn) begin
            lvl[ump_pkg::PIN_DCD] = st_r.modem_control_reg[ump_pkg::MCR_USER_B];
            lvl[ump_pkg::PIN_DSR] = st_r.modem_control_reg[ump_pkg::MCR_DTR];
            lvl[ump_pkg::PIN_CTS] = st_r.modem_control_reg[ump_pkg::MCR_RTS];
            lvl[ump_pkg::PIN_RI] = st_r.modem_control_reg[ump_pkg::MCR_USER_A];
        end
    end

    // Change detection; ring counts only when the pin returns high
    always_comb begin
        chg = lvl ^ st_r.lvlPrev;
        chg[ump_pkg::PIN_RI] = st_r.lvlPrev[ump_pkg::PIN_RI] & ~lvl[ump_pkg::PIN_RI];
    end

    // Modem status image: live levels high, change flags low
    always_comb begin
        msrVal = 8'h00;
        msrVal[ump_pkg::MSR_DCD] = lvl[ump_pkg::PIN_DCD];
        msrVal[ump_pkg::MSR_DSR] = lvl[ump_pkg::PIN_DSR];
        msrVal[ump_pkg::MSR_CTS] = lvl[ump_pkg::PIN_CTS];
        msrVal[ump_pkg::MSR_RI] = lvl[ump_pkg::PIN_RI];
        msrVal[ump_pkg::MSR_D_DCD] = st_r.delta[ump_pkg::PIN_DCD];
        msrVal[ump_pkg::MSR_D_DSR] = st_r.delta[ump_pkg::PIN_DSR];
        msrVal[ump_pkg::MSR_D_CTS] = st_r.delta[ump_pkg::PIN_CTS];
        msrVal[ump_pkg::MSR_RING_TRAIL] = st_r.delta[ump_pkg::PIN_RI];
    end

    // Read mux; unmapped and write cycles return zero
    always_comb begin
        prdata = 32'h00000000;
        if (rdAcc) begin
            case (paddr)
                ump_pkg::ADDR_INT_STAT: prdata = {28'h0000000, intStat};
                ump_pkg::ADDR_INT_MASK: prdata = {28'h0000000, intMask};
                ump_pkg::ADDR_MODEM_CTRL: prdata = {25'h0000000, st_r.modem_control_reg};
                ump_pkg::ADDR_MODEM_STAT: prdata = {24'h000000, msrVal};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // Data lines mirror the read byte and are driven only in a read
    assign cpuDataOut = prdata[7:0];
    assign cpuDataOe_n = ~(psel & ~pwrite);
    assign busDriverDisable = ~(psel & ~pwrite);

    // Clear to send changes stay silent while it steers the transmitter
    assign modemEvt = chg[ump_pkg::PIN_DCD] | chg[ump_pkg::PIN_DSR] | chg[ump_pkg::PIN_RI]
        | (chg[ump_pkg::PIN_CTS] & ~st_r.modem_control_reg[ump_pkg::MCR_AUTO_CTS]);
    assign txCtsHold = st_r.modem_control_reg[ump_pkg::MCR_AUTO_CTS] & ~lvl[ump_pkg::PIN_CTS];

    // Interrupt sources; reading modem status services the modem source
    always_comb begin
        intSet = 4'h0;
        intSet[ump_pkg::INT_RX_ERR] = rxErrEvt;
        intSet[ump_pkg::INT_RX_DATA] = rxDataEvt;
        intSet[ump_pkg::INT_THR_EMPTY] = thrEmptyEvt;
        intSet[ump_pkg::INT_MODEM] = modemEvt;
        intClr = 4'h0;
        if (wrAcc && paddr == ump_pkg::ADDR_INT_STAT) begin
            intClr = pwdata[3:0];
        end
        intClr[ump_pkg::INT_MODEM] = intClr[ump_pkg::INT_MODEM] | msrRead;
    end

    ump_irq u_irq (
        .sys_clk(sys_clk),
        .rst(rst),
        .setBits(intSet),
        .clrBits(intClr),
        .maskWe(wrAcc && paddr == ump_pkg::ADDR_INT_MASK),
        .maskWdata(pwdata[3:0]),
        .statBits(intStat),
        .maskBits(intMask),
        .irq(irqOut)
    );

    // Next state: control register, change flags, registered pin drives
    always_comb begin
        st_nxt = st_r;
        st_nxt.lvlPrev = lvl;
        // Flags clear on the reading edge, but a change in that cycle survives
        if (msrRead) begin
            st_nxt.delta = 4'h0;
        end
        st_nxt.delta = st_nxt.delta | chg;
        if (wrAcc && paddr == ump_pkg::ADDR_MODEM_CTRL) begin
            st_nxt.modem_control_reg = pwdata[6:0];
        end
        st_nxt.dtrN = ~(st_r.modem_control_reg[ump_pkg::MCR_DTR] & ~loopOn);
        st_nxt.rtsN = ~(st_r.modem_control_reg[ump_pkg::MCR_RTS] & ~loopOn
            & ~(st_r.modem_control_reg[ump_pkg::MCR_AUTO_RTS] & rxAboveThresh));
        st_nxt.userAN = ~(st_r.modem_control_reg[ump_pkg::MCR_USER_A] & ~loopOn);
        st_nxt.userBN = ~(st_r.modem_control_reg[ump_pkg::MCR_USER_B] & ~loopOn);
        // Receiver clock is sampled, so it must stay below half of sys_clk
        st_nxt.rclkPrev = pinSync[ump_pkg::PIN_RCLK];
        st_nxt.rxTick = pinSync[ump_pkg::PIN_RCLK] & ~st_r.rclkPrev;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dtr_n = st_r.dtrN;
    assign rts_n = st_r.rtsN;
    assign userPinA_n = st_r.userAN;
    assign userPinB_n = st_r.userBN;
    assign rxSampleTick = st_r.rxTick;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_mcr_write;
        wrAcc && paddr == ump_pkg::ADDR_MODEM_CTRL && !pwdata[ump_pkg::MCR_LOOP];
    endsequence

    property p_drv_disable;
        (busDriverDisable == cpuDataOe_n) and (rdAcc |-> !busDriverDisable)
            and (!psel |-> busDriverDisable);
    endproperty
    a_drv_disable: assert property (p_drv_disable) else $error("driver disable wrong");

    property p_dcd_level;
        (!loopOn && !dcd_n && !pinSync[ump_pkg::PIN_MCLR])[*3] |-> msrVal[ump_pkg::MSR_DCD];
    endproperty
    a_dcd_level: assert property (p_dcd_level) else $error("carrier level missing");

    property p_dsr_level;
        (!loopOn && dsr_n)[*3] |-> !msrVal[ump_pkg::MSR_DSR];
    endproperty
    a_dsr_level: assert property (p_dsr_level) else $error("ready level wrong");

    property p_delta_set;
        $changed(lvl[ump_pkg::PIN_DCD]) && !rst |=> st_r.delta[ump_pkg::PIN_DCD];
    endproperty
    a_delta_set: assert property (p_delta_set) else $error("carrier change lost");

    property p_msr_clear;
        msrRead && chg == 4'h0 && !rst |=> st_r.delta == 4'h0;
    endproperty
    a_msr_clear: assert property (p_msr_clear) else $error("flags not cleared");

    property p_dtr_on;
        s_mcr_write ##1 (!rst && !wrAcc) |-> ##1 (dtr_n == !$past(st_r.modem_control_reg[ump_pkg::MCR_DTR]));
    endproperty
    a_dtr_on: assert property (p_dtr_on) else $error("terminal ready wrong");

    property p_loop_idle;
        loopOn && !rst |=> dtr_n && rts_n && userPinA_n && userPinB_n;
    endproperty
    a_loop_idle: assert property (p_loop_idle) else $error("outputs active in loop");

    property p_irq_raise;
        rxErrEvt && intMask[ump_pkg::INT_RX_ERR] && !rst && !wrAcc |=> irqOut;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

    property p_mclr;
        pinSync[ump_pkg::PIN_MCLR] |=> dtr_n && rts_n && userPinA_n && !irqOut;
    endproperty
    a_mclr: assert property (p_mclr) else $error("master clear ignored");

    property p_auto_rts;
        st_r.modem_control_reg[ump_pkg::MCR_AUTO_RTS] && rxAboveThresh && !rst |=> rts_n;
    endproperty
    a_auto_rts: assert property (p_auto_rts) else $error("auto rts ignored");

    // Ring input leaves its asserted level with no reset on either edge
    sequence s_ring_trail;
        (lvl[ump_pkg::PIN_RI] && !rst) ##1 (!lvl[ump_pkg::PIN_RI] && !rst);
    endsequence

    // Synchronised receiver clock rises outside reset
    sequence s_rclk_rise;
        !pinSync[ump_pkg::PIN_RCLK] ##1 (pinSync[ump_pkg::PIN_RCLK] && !rst);
    endsequence

    property p_data_idle;
        (!psel || pwrite) |-> cpuDataOe_n;
    endproperty
    a_data_idle: assert property (p_data_idle) else $error("data lines driven");

    property p_data_read;
        rdAcc |-> !cpuDataOe_n && cpuDataOut == prdata[7:0];
    endproperty
    a_data_read: assert property (p_data_read) else $error("read byte missing");

    property p_irq_any;
        (intSet & intMask) != 4'h0 && !rst && !wrAcc |=> irqOut;
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("enabled event lost");

    // Clearing every source with no new event must drop the line
    property p_irq_service;
        wrAcc && paddr == ump_pkg::ADDR_INT_STAT && pwdata[3:0] == 4'hf
            && intSet == 4'h0 && !rst |=> !irqOut;
    endproperty
    a_irq_service: assert property (p_irq_service) else $error("interrupt stuck");

    property p_user_a;
        s_mcr_write ##1 (!rst && !wrAcc)
            |-> ##1 (userPinA_n == !$past(st_r.modem_control_reg[ump_pkg::MCR_USER_A]));
    endproperty
    a_user_a: assert property (p_user_a) else $error("user pin a wrong");

    property p_user_b;
        s_mcr_write ##1 (!rst && !wrAcc)
            |-> ##1 (userPinB_n == !$past(st_r.modem_control_reg[ump_pkg::MCR_USER_B]));
    endproperty
    a_user_b: assert property (p_user_b) else $error("user pin b wrong");

    property p_cts_flag;
        chg[ump_pkg::PIN_CTS] && !rst |=> st_r.delta[ump_pkg::PIN_CTS];
    endproperty
    a_cts_flag: assert property (p_cts_flag) else $error("send change lost");

    // A lone send change under auto mode must not raise the modem source
    property p_cts_quiet;
        chg == (4'h1 << ump_pkg::PIN_CTS) && st_r.modem_control_reg[ump_pkg::MCR_AUTO_CTS]
            && !intStat[ump_pkg::INT_MODEM] && !rst |=> !intStat[ump_pkg::INT_MODEM];
    endproperty
    a_cts_quiet: assert property (p_cts_quiet) else $error("auto send interrupted");

    property p_ring_trail;
        s_ring_trail |=> st_r.delta[ump_pkg::PIN_RI];
    endproperty
    a_ring_trail: assert property (p_ring_trail) else $error("ring edge lost");

    property p_rx_tick;
        s_rclk_rise |=> rxSampleTick;
    endproperty
    a_rx_tick: assert property (p_rx_tick) else $error("receiver tick lost");

    property p_mclr_regs;
        pinSync[ump_pkg::PIN_MCLR]
            |=> st_r.modem_control_reg == ump_pkg::MCR_RST && intMask == ump_pkg::INT_MASK_RST;
    endproperty
    a_mclr_regs: assert property (p_mclr_regs) else $error("registers kept");
endmodule

// ===== ump_pkg.sv
package ump_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] ADDR_INT_STAT = 8'h00;
    localparam logic [7:0] ADDR_INT_MASK = 8'h04;
    localparam logic [7:0] ADDR_MODEM_CTRL = 8'h08;
    localparam logic [7:0] ADDR_MODEM_STAT = 8'h0c;

    // Modem control register fields
    localparam int MCR_W = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_USER_A = 2;
    localparam int MCR_USER_B = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_AUTO_RTS = 5;
    localparam int MCR_AUTO_CTS = 6;
    localparam logic [6:0] MCR_RST = 7'h00;

    // Modem status register fields
    localparam int MSR_D_CTS = 0;
    localparam int MSR_D_DSR = 1;
    localparam int MSR_RING_TRAIL = 2;
    localparam int MSR_D_DCD = 3;
    localparam int MSR_CTS = 4;
    localparam int MSR_DSR = 5;
    localparam int MSR_RI = 6;
    localparam int MSR_DCD = 7;

    // Interrupt status and mask fields
    localparam int INT_W = 4;
    localparam int INT_RX_ERR = 0;
    localparam int INT_RX_DATA = 1;
    localparam int INT_THR_EMPTY = 2;
    localparam int INT_MODEM = 3;
    localparam logic [3:0] INT_MASK_RST = 4'h0;

    // Index of each modem line inside the synchronised pin vector
    localparam int PIN_DCD = 0;
    localparam int PIN_DSR = 1;
    localparam int PIN_CTS = 2;
    localparam int PIN_RI = 3;
    localparam int PIN_MCLR = 4;
    localparam int PIN_RCLK = 5;
    localparam int PIN_W = 6;
    localparam logic [5:0] PIN_SYNC_RST = 6'h0f;
endpackage

// ===== ump_sync.sv
`timescale 1ns/1ps
module ump_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [W-1:0] din, // Asynchronous pin levels
    output logic [W-1:0] dout // Levels in the sys_clk domain
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } ump_sync_state_t;

    ump_sync_state_t st_r;
    ump_sync_state_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.stage1 = din;
        st_nxt.stage2 = st_r.stage1;
    end

    // Pins rest at their idle level while in reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '{stage1: RST_VAL, stage2: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.stage2;
endmodule

// ===== ump_irq.sv
`timescale 1ns/1ps
module ump_irq (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [3:0] setBits, // Event pulses, one per source
    input wire logic [3:0] clrBits, // Clear strobes, one per source
    input wire logic maskWe, // Mask register write strobe
    input wire logic [3:0] maskWdata, // Mask register write data
    output logic [3:0] statBits, // Sticky status
    output logic [3:0] maskBits, // Enable mask
    output logic irq // Level interrupt
);
    typedef struct packed {
        logic [3:0] stat;
        logic [3:0] mask;
        logic irq;
    } ump_irq_state_t;

    ump_irq_state_t st_r;
    ump_irq_state_t st_nxt;

    // Set is applied after clear, so an event in the clearing cycle survives
    always_comb begin
        st_nxt = st_r;
        st_nxt.stat = (st_r.stat & ~clrBits) | setBits;
        if (maskWe) begin
            st_nxt.mask = maskWdata;
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '{stat: 4'h0, mask: ump_pkg::INT_MASK_RST, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign statBits = st_r.stat;
    assign maskBits = st_r.mask;
    assign irq = st_r.irq;
endmodule

// ===== ump_modem_model.sv
`timescale 1ns/1ps
module ump_modem_model #(
    parameter int LAG = 3
) (
    input wire logic sys_clk, // System clock
    input wire logic [3:0] assertReq, // Wanted asserted lines, pin order
    input wire logic rclkRun, // Run the receiver clock
    output logic dcd_n, // Carrier detect pin
    output logic dsr_n, // Data set ready pin
    output logic cts_n, // Clear to send pin
    output logic ri_n, // Ring indicator pin
    output logic rclk16x // Receiver 16x clock
);
    logic [3:0] lagQ [0:LAG];
    logic [1:0] div;

    // A real modem answers late, so requests pass a delay line first
    initial begin
        foreach (lagQ[i]) lagQ[i] = 4'h0;
        div = 2'h0;
        rclk16x = 1'b0;
    end
    always @(posedge sys_clk) begin
        lagQ[0] <= assertReq;
        for (int i = 1; i <= LAG; i++) lagQ[i] <= lagQ[i-1];
    end
    assign dcd_n = ~lagQ[LAG][ump_pkg::PIN_DCD];
    assign dsr_n = ~lagQ[LAG][ump_pkg::PIN_DSR];
    assign cts_n = ~lagQ[LAG][ump_pkg::PIN_CTS];
    assign ri_n = ~lagQ[LAG][ump_pkg::PIN_RI];

    // Slow enough for the sampled pin: one rise every six system cycles
    always @(posedge sys_clk) begin
        if (rclkRun) begin
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (div == 2'h2) rclk16x <= ~rclk16x;
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic sys_clk, sys_rst, psel, penable, pwrite, masterClear, rxAboveThresh, rclkRun, errSeen;
    logic [7:0] paddr, cpuDataOut, lineVal;
    logic [31:0] pwdata, prdata, rdVal;
    logic [2:0] evt;
    logic [3:0] lv, pinExp;
    logic pready, pslverr, cpuDataOe_n, busDriverDisable, dcd_n, dsr_n, cts_n, ri_n;
    logic dtr_n, rts_n, userPinA_n, userPinB_n, rclk16x, rxSampleTick, txCtsHold, irqOut;
    int mismatches = 0;
    int compares = 0;
    int ticks = 0;
    int rises = 0;
    logic [3:0] stp [5] = '{4'h1, 4'h3, 4'h7, 4'hf, 4'h7};
    logic [7:0] flg [5] = '{8'h08, 8'h02, 8'h01, 8'h00, 8'h04};
    logic irqE [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    wire [3:0] pins = {userPinB_n, userPinA_n, rts_n, dtr_n};

    ump_top dut (.sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .cpuDataOut, .cpuDataOe_n, .busDriverDisable, .dcd_n, .dsr_n,
        .cts_n, .ri_n, .dtr_n, .rts_n, .userPinA_n, .userPinB_n, .masterClear, .rclk16x,
        .rxSampleTick, .rxErrEvt(evt[0]), .rxDataEvt(evt[1]), .thrEmptyEvt(evt[2]),
        .rxAboveThresh, .txCtsHold, .irqOut);
    ump_modem_model #(.LAG(3)) modem (.sys_clk, .assertReq(lv), .rclkRun, .dcd_n, .dsr_n,
        .cts_n, .ri_n, .rclk16x);

    // Clock, and independent counts of receiver clock rises and ticks
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (rxSampleTick === 1'b1) ticks <= ticks + 1;
    always @(posedge rclk16x) rises <= rises + 1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Let n edges pass, then look where outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // One APB transfer; the answer is taken at the edge that samples pready high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        logic rdy;
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        rdy = 1'b0;
        while (rdy !== 1'b1) begin
            @(posedge sys_clk);
            rdy = pready;
            rdVal = prdata;
            lineVal = cpuDataOut;
            errSeen = pslverr;
            chk(32'(busDriverDisable), 32'(w));
            chk(32'(cpuDataOe_n), 32'(w));
            if (!w) chk(32'(cpuDataOut), 32'(prdata[7:0]));
            n++;
            if (n > 20) begin
                mismatches++;
                stop_test();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0);
    endtask

    function automatic logic [31:0] msrLv(input logic [3:0] l);
        return {24'h0, l[ump_pkg::PIN_DCD], l[ump_pkg::PIN_RI], l[ump_pkg::PIN_DSR],
            l[ump_pkg::PIN_CTS], 4'h0};
    endfunction

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        masterClear = 1'b0;
        rxAboveThresh = 1'b0;
        evt = 3'h0;
        lv = 4'h0;
        rclkRun = 1'b0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        settle(1);
        chk(32'(pins), 32'hf);
        chk(32'(irqOut), 32'h0);
        rd(ump_pkg::ADDR_MODEM_CTRL);
        chk(rdVal, 32'h0);
        rd(ump_pkg::ADDR_MODEM_STAT);
        chk(rdVal, 32'h0);
        rd(8'h10);
        chk(32'(errSeen), 32'h1);
        settle(0);
        chk(32'(busDriverDisable), 32'h1);
        // Each of the four pin control bits alone; the previous one is cleared by the next write
        for (int i = 0; i < 4; i++) begin
            wr(ump_pkg::ADDR_MODEM_CTRL, 32'h1 << i);
            settle(2);
            pinExp = ~(4'h1 << i);
            chk(32'(pins), 32'(pinExp));
        end
        wr(ump_pkg::ADDR_MODEM_CTRL, 32'h1f);
        settle(2);
        chk(32'(pins), 32'hf);
        wr(ump_pkg::ADDR_MODEM_CTRL, 32'h0);
        settle(8);
        rd(ump_pkg::ADDR_MODEM_STAT);
        rd(ump_pkg::ADDR_MODEM_STAT);
        chk(rdVal, 32'h0);
        wr(ump_pkg::ADDR_INT_STAT, 32'hf);
        wr(ump_pkg::ADDR_INT_MASK, 32'h8);
        // Modem lines in turn, ending with a ring trailing edge
        for (int i = 0; i < 5; i++) begin
            lv <= stp[i];
            settle(10);
            chk(32'(irqOut), 32'(irqE[i]));
            rd(ump_pkg::ADDR_MODEM_STAT);
            chk(rdVal, msrLv(stp[i]) | 32'(flg[i]));
            chk(32'(lineVal), msrLv(stp[i]) | 32'(flg[i]));
        end
        settle(3);
        chk(32'(irqOut), 32'h0);
        wr(ump_pkg::ADDR_MODEM_CTRL, 32'h40);
        lv <= 4'h3;
        settle(10);
        chk(32'(txCtsHold), 32'h1);
        chk(32'(irqOut), 32'h0);
        rd(ump_pkg::ADDR_MODEM_STAT);
        chk(rdVal, 32'ha1);
        wr(ump_pkg::ADDR_MODEM_CTRL, 32'h22);
        settle(2);
        chk(32'(rts_n), 32'h0);
        @(posedge sys_clk);
        rxAboveThresh <= 1'b1;
        settle(4);
        chk(32'(rts_n), 32'h1);
        wr(ump_pkg::ADDR_INT_MASK, 32'h0);
        lv <= 4'h0;
        rxAboveThresh <= 1'b0;
        settle(10);
        rd(ump_pkg::ADDR_MODEM_STAT);
        wr(ump_pkg::ADDR_INT_STAT, 32'hf);
        // Each event: sticky when masked, raises the line once enabled
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            evt <= 3'h1 << i;
            @(posedge sys_clk);
            evt <= 3'h0;
            settle(3);
            chk(32'(irqOut), 32'h0);
            rd(ump_pkg::ADDR_INT_STAT);
            chk(rdVal, 32'h1 << i);
            wr(ump_pkg::ADDR_INT_MASK, 32'h1 << i);
            settle(2);
            chk(32'(irqOut), 32'h1);
            wr(ump_pkg::ADDR_INT_STAT, 32'h1 << i);
            settle(2);
            chk(32'(irqOut), 32'h0);
        end
        @(posedge sys_clk);
        rclkRun <= 1'b1;
        settle(40);
        rclkRun <= 1'b0;
        settle(6);
        chk(32'(ticks), 32'(rises));
        // Master reset drops pins, interrupt and control register
        wr(ump_pkg::ADDR_MODEM_CTRL, 32'hf);
        wr(ump_pkg::ADDR_INT_MASK, 32'h1);
        evt <= 3'h1;
        @(posedge sys_clk);
        evt <= 3'h0;
        settle(3);
        chk(32'(pins), 32'h0);
        chk(32'(irqOut), 32'h1);
        @(posedge sys_clk);
        masterClear <= 1'b1;
        settle(5);
        chk(32'(pins), 32'hf);
        chk(32'(irqOut), 32'h0);
        @(posedge sys_clk);
        masterClear <= 1'b0;
        settle(4);
        rd(ump_pkg::ADDR_MODEM_CTRL);
        chk(rdVal, 32'h0);
        stop_test();
    end
endmodule
